// [pcpi_defs.svh]
// Purpose: Constants of the control-pin block: offsets, fields, resets, times
// Assumes: Slow timebase near 32 kHz derived from CLK
// Notes: Times are in microseconds; tick counts round up
`ifndef PCPI_DEFS_SVH
`define PCPI_DEFS_SVH
// ----------------------------------------
// Target address and register pointers
// ----------------------------------------
`define PCPI_I2C_ADDR 7'h08
`define PCPI_REG_STATUS 8'h00
`define PCPI_REG_MASK 8'h01
`define PCPI_REG_SENSE 8'h02
`define PCPI_REG_CONFIG 8'h03
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PCPI_IRQ_BTN_REL 0
`define PCPI_IRQ_BTN_PRS 1
`define PCPI_IRQ_FAULT 2
`define PCPI_IRQ_STBY 3
`define PCPI_CFG_POL 0
`define PCPI_CFG_HOLD 2:1
`define PCPI_CFG_DBNC 4:3
`define PCPI_MASK_RST 4'hF
`define PCPI_STATUS_RST 4'h0
`define PCPI_CFG_RST 5'h00
`define PCPI_SYNC_RST 5'h1E
// ----------------------------------------
// Timing
// ----------------------------------------
`define PCPI_CLK_HZ 25000000
`define PCPI_SLOW_HZ 32768
`define PCPI_SLOW_DIV ((`PCPI_CLK_HZ + `PCPI_SLOW_HZ - 1) / `PCPI_SLOW_HZ)
`define PCPI_TK(us) ((64'(us) * `PCPI_SLOW_HZ + 64'd999999) / 64'd1000000)
`define PCPI_T_DBNC_SHORT_US 31250
`define PCPI_T_DBNC_MID_US 125000
`define PCPI_T_DBNC_LONG_US 750000
`define PCPI_T_FLT_RST_US 1800
`define PCPI_T_FLT_OFF_US 100000
`define PCPI_T_HOLD_STEP_US 1000
`define PCPI_T_LP0_US 4000000
`define PCPI_T_LP1_US 8000000
`define PCPI_T_LP2_US 12000000
`define PCPI_T_LP3_US 16000000
`define PCPI_T_POR_BASE_US 2000
`define PCPI_T_POR_MAX_US 1024000
`endif

// [pcpi_pkg.sv]
// Purpose: Types shared by the control-pin block
// Assumes: Nothing
// Notes: States carry no explicit codes
package pcpi_pkg;
  typedef enum logic [2:0] {PWR_OFF, PWR_START, PWR_RDLY, PWR_RUN, PWR_STBY} pcpi_pwr_st_t;
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WRB, I2C_RDB, I2C_RACK, I2C_RNXT
  } pcpi_i2c_st_t;
endpackage

// [pcpi_reg_if.sv]
// Purpose: Register access path from the serial target to the register set
// Assumes: Single clock
// Notes: rdata is combinational from rd_addr
`timescale 1ns/100ps
`default_nettype none
interface pcpi_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  modport tgt(output wr_en, output addr, output wdata, output rd_addr, input rdata);
  modport regs(input wr_en, input addr, input wdata, input rd_addr, output rdata);
endinterface
`default_nettype wire

// [pcpi_i2c_tgt.sv]
// Purpose: Serial two-wire target, 7-bit address, pointer then data bytes
// Assumes: CLK far faster than the bus clock
// Notes: Never stretches the clock
`timescale 1ns/100ps
`default_nettype none
`include "pcpi_defs.svh"
module pcpi_i2c_tgt import pcpi_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  pcpi_reg_if.tgt bus
);
  logic [1:0] scl_s_r, sda_s_r;
  logic scl_q_r, sda_q_r;
  pcpi_i2c_st_t st_r, st_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, byte_in;
  logic rw_r, rw_nxt, first_r, first_nxt, oe_r, oe_nxt;
  logic scl, sda, rise, fall, start, stop;

  assign scl = scl_s_r[1];
  assign sda = sda_s_r[1];
  assign rise = scl & ~scl_q_r;
  assign fall = ~scl & scl_q_r;
  assign start = scl & scl_q_r & sda_q_r & ~sda;
  assign stop = scl & scl_q_r & ~sda_q_r & sda;
  assign byte_in = {sh_r[6:0], sda};
  assign sda_oe = oe_r;
  assign bus.rd_addr = ptr_r;

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    oe_nxt = oe_r;
    bus.wr_en = 1'b0;
    bus.addr = ptr_r;
    bus.wdata = byte_in;
    if (start) begin
      st_nxt = I2C_ADDR;
      bit_nxt = 3'h0;
      oe_nxt = 1'b0;
    end else if (stop) begin
      st_nxt = I2C_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        I2C_ADDR: if (rise) begin
          sh_nxt = byte_in;
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            rw_nxt = sda;
            first_nxt = 1'b1;
            // General call never matches, so it is left unanswered
            st_nxt = (sh_r[6:0] == `PCPI_I2C_ADDR) ? I2C_AACK : I2C_IDLE;
          end
        end
        I2C_AACK: if (fall) begin
          if (!oe_r) begin
            oe_nxt = 1'b1;
          end else if (rw_r) begin
            st_nxt = I2C_RDB;
            sh_nxt = bus.rdata;
            oe_nxt = ~bus.rdata[7];
            bit_nxt = 3'h0;
            ptr_nxt = ptr_r + 8'h01;
          end else begin
            oe_nxt = 1'b0;
            st_nxt = I2C_WRB;
            bit_nxt = 3'h0;
          end
        end
        I2C_WRB: if (rise) begin
          sh_nxt = byte_in;
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            st_nxt = I2C_AACK;
            if (first_r) begin
              ptr_nxt = byte_in;
              first_nxt = 1'b0;
            end else begin
              bus.wr_en = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        I2C_RDB: if (fall) begin
          if (bit_r == 3'h7) begin
            oe_nxt = 1'b0;
            st_nxt = I2C_RACK;
          end else begin
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_nxt = ~sh_r[6];
            bit_nxt = bit_r + 3'h1;
          end
        end
        I2C_RACK: if (rise) begin
          st_nxt = sda ? I2C_IDLE : I2C_RNXT;
        end
        I2C_RNXT: if (fall) begin
          st_nxt = I2C_RDB;
          sh_nxt = bus.rdata;
          oe_nxt = ~bus.rdata[7];
          bit_nxt = 3'h0;
          ptr_nxt = ptr_r + 8'h01;
        end
        default: st_nxt = I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      st_r <= I2C_IDLE;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      scl_q_r <= scl;
      sda_q_r <= sda;
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      oe_r <= oe_nxt;
    end
  end
endmodule
`default_nettype wire

// [pcpi_top.sv]
// Purpose: Control pins of a power manager: request, reset, interrupt, keys
// Assumes: POWER_ON_CMD, SEQ_DONE and FAULT_IN come from logic on CLK
// Notes: Slow timebase is a tick enable; SLOW_DIV shortens every timer
`timescale 1ns/100ps
`default_nettype none
`include "pcpi_defs.svh"
module pcpi_top import pcpi_pkg::*; #(
  parameter int SLOW_DIV = `PCPI_SLOW_DIV
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic LP_REQUEST_IN,
  input wire logic WATCHDOG_HARD_RESET_IN,
  input wire logic PUSH_BUTTON_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic PROCESSOR_RESET_OUT_N_I,
  output logic PROCESSOR_RESET_OUT_N_O,
  output logic PROCESSOR_RESET_OUT_N_OE,
  input wire logic IRQ_OUT_N_I,
  output logic IRQ_OUT_N_O,
  output logic IRQ_OUT_N_OE,
  input wire logic POWER_ON_CMD,
  input wire logic SEQ_DONE,
  input wire logic FAULT_IN,
  input wire logic FAULT_RESET_MODE_ENABLE,
  input wire logic [2:0] RESET_RELEASE_DELAY_SEL,
  input wire logic [1:0] LONG_PRESS_TIME_SEL,
  output logic REGS_ON,
  output logic STANDBY_ACTIVE
);
  localparam logic [6:0] HOLD_STEP_TK = 7'(`PCPI_TK(`PCPI_T_HOLD_STEP_US));
  localparam logic [14:0] DB_SHORT_TK = 15'(`PCPI_TK(`PCPI_T_DBNC_SHORT_US));
  localparam logic [14:0] DB_MID_TK = 15'(`PCPI_TK(`PCPI_T_DBNC_MID_US));
  localparam logic [14:0] DB_LONG_TK = 15'(`PCPI_TK(`PCPI_T_DBNC_LONG_US));
  localparam logic [11:0] FLT_RST_TK = 12'(`PCPI_TK(`PCPI_T_FLT_RST_US));
  localparam logic [11:0] FLT_OFF_TK = 12'(`PCPI_TK(`PCPI_T_FLT_OFF_US));
  localparam logic [15:0] POR_BASE_TK = 16'(`PCPI_TK(`PCPI_T_POR_BASE_US));
  localparam logic [15:0] POR_MAX_TK = 16'(`PCPI_TK(`PCPI_T_POR_MAX_US));
  localparam logic [19:0] LP0_TK = 20'(`PCPI_TK(`PCPI_T_LP0_US));
  localparam logic [19:0] LP1_TK = 20'(`PCPI_TK(`PCPI_T_LP1_US));
  localparam logic [19:0] LP2_TK = 20'(`PCPI_TK(`PCPI_T_LP2_US));
  localparam logic [19:0] LP3_TK = 20'(`PCPI_TK(`PCPI_T_LP3_US));

  pcpi_reg_if rif();

  pcpi_i2c_tgt u_i2c (
    .clk(CLK),
    .rst(SYS_RST),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .sda_oe(SDA_OE),
    .bus(rif.tgt)
  );

  // ----------------------------------------
  // Synchronisers and slow tick
  // ----------------------------------------
  logic [4:0] s1_r, s2_r, pins;
  logic [9:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  logic req_pin, wdog_ok, btn_prs, rst_pin, irq_pin;

  assign pins = {IRQ_OUT_N_I, PROCESSOR_RESET_OUT_N_I, PUSH_BUTTON_IN,
                 WATCHDOG_HARD_RESET_IN, LP_REQUEST_IN};
  assign req_pin = s2_r[0];
  assign wdog_ok = s2_r[1];
  assign btn_prs = ~s2_r[2];
  assign rst_pin = s2_r[3];
  assign irq_pin = s2_r[4];

  always_comb begin
    tick_nxt = (div_r == 10'(SLOW_DIV - 1));
    div_nxt = tick_nxt ? 10'h000 : div_r + 10'h001;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1_r <= `PCPI_SYNC_RST;
      s2_r <= `PCPI_SYNC_RST;
      div_r <= 10'h000;
      tick_r <= 1'b0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ----------------------------------------
  // Low-power request
  // ----------------------------------------
  logic [4:0] cfg_r, cfg_nxt;
  logic [2:0] rq_sh_r, rq_sh_nxt;
  logic [6:0] hold_r, hold_nxt, hold_lim;
  logic req_eff_r, req_eff_nxt, req_raw, req_q;

  always_comb begin
    req_raw = req_pin ^ cfg_r[`PCPI_CFG_POL];
    req_q = rq_sh_r[2];
    rq_sh_nxt = tick_r ? {rq_sh_r[1:0], req_raw} : rq_sh_r;
    hold_lim = 7'(cfg_r[`PCPI_CFG_HOLD]) * HOLD_STEP_TK;
    req_eff_nxt = req_eff_r;
    hold_nxt = hold_r;
    // Only entry is held off; leaving standby is not delayed
    if (req_q == req_eff_r) begin
      hold_nxt = 7'h00;
    end else if (!req_q || hold_r >= hold_lim) begin
      req_eff_nxt = req_q;
      hold_nxt = 7'h00;
    end else if (tick_r) begin
      hold_nxt = hold_r + 7'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rq_sh_r <= 3'h0;
      hold_r <= 7'h00;
      req_eff_r <= 1'b0;
    end else begin
      rq_sh_r <= rq_sh_nxt;
      hold_r <= hold_nxt;
      req_eff_r <= req_eff_nxt;
    end
  end

  // ----------------------------------------
  // Push-button debounce and long press
  // ----------------------------------------
  logic btn_db_r, btn_db_nxt, lp_done_r, lp_done_nxt;
  logic [14:0] dbc_r, dbc_nxt, db_lim;
  logic [19:0] lp_r, lp_nxt, lp_lim;
  logic btn_rel_ev, btn_prs_ev, long_ev;

  always_comb begin
    case (cfg_r[`PCPI_CFG_DBNC])
      2'h2: db_lim = DB_MID_TK;
      2'h3: db_lim = DB_LONG_TK;
      default: db_lim = DB_SHORT_TK;
    endcase
    if (btn_db_r) begin
      db_lim = DB_SHORT_TK;
    end
    case (LONG_PRESS_TIME_SEL)
      2'h0: lp_lim = LP0_TK;
      2'h1: lp_lim = LP1_TK;
      2'h2: lp_lim = LP2_TK;
      default: lp_lim = LP3_TK;
    endcase
    btn_db_nxt = btn_db_r;
    dbc_nxt = dbc_r;
    btn_rel_ev = 1'b0;
    btn_prs_ev = 1'b0;
    if (btn_prs == btn_db_r) begin
      dbc_nxt = 15'h0000;
    end else if (dbc_r >= db_lim) begin
      btn_db_nxt = btn_prs;
      dbc_nxt = 15'h0000;
      btn_prs_ev = btn_prs;
      btn_rel_ev = ~btn_prs;
    end else if (tick_r) begin
      dbc_nxt = dbc_r + 15'h0001;
    end
    long_ev = btn_db_r && !lp_done_r && (lp_r >= lp_lim);
    lp_nxt = lp_r;
    lp_done_nxt = lp_done_r | long_ev;
    if (!btn_db_r) begin
      lp_nxt = 20'h00000;
      lp_done_nxt = 1'b0;
    end else if (tick_r && !lp_done_r && !long_ev) begin
      lp_nxt = lp_r + 20'h00001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      btn_db_r <= 1'b0;
      dbc_r <= 15'h0000;
      lp_r <= 20'h00000;
      lp_done_r <= 1'b0;
    end else begin
      btn_db_r <= btn_db_nxt;
      dbc_r <= dbc_nxt;
      lp_r <= lp_nxt;
      lp_done_r <= lp_done_nxt;
    end
  end

  // ----------------------------------------
  // Power state, processor reset, fault timer
  // ----------------------------------------
  pcpi_pwr_st_t st_r, st_nxt;
  logic [15:0] por_r, por_nxt, por_lim;
  logic [11:0] flt_r, flt_nxt;
  logic rst_oe_r, rst_oe_nxt, fseen_r, fseen_nxt, flt_q_r;
  logic regs_r, stby_r, flt_rst, flt_off, sys_on;

  always_comb begin
    case (RESET_RELEASE_DELAY_SEL)
      3'h6: por_lim = POR_BASE_TK << 7;
      3'h7: por_lim = POR_MAX_TK;
      default: por_lim = POR_BASE_TK << RESET_RELEASE_DELAY_SEL;
    endcase
    flt_nxt = (FAULT_IN && st_r != PWR_OFF) ? flt_r : 12'h000;
    if (FAULT_IN && st_r != PWR_OFF && tick_r && flt_r != 12'hFFF) begin
      flt_nxt = flt_r + 12'h001;
    end
    flt_rst = FAULT_RESET_MODE_ENABLE && (flt_r >= FLT_RST_TK);
    flt_off = FAULT_RESET_MODE_ENABLE && (flt_r >= FLT_OFF_TK);
    sys_on = (st_r == PWR_RUN) || (st_r == PWR_STBY);
    st_nxt = st_r;
    por_nxt = por_r;
    rst_oe_nxt = rst_oe_r;
    fseen_nxt = fseen_r | (FAULT_IN && !sys_on);
    case (st_r)
      PWR_OFF: begin
        rst_oe_nxt = 1'b1;
        if (POWER_ON_CMD || btn_prs_ev) begin
          st_nxt = PWR_START;
          fseen_nxt = 1'b0;
        end
      end
      PWR_START: if (SEQ_DONE) begin
        st_nxt = PWR_RDLY;
        por_nxt = 16'h0000;
      end
      PWR_RDLY: if (por_r >= por_lim) begin
        if (!(FAULT_RESET_MODE_ENABLE && fseen_r)) begin
          st_nxt = PWR_RUN;
          rst_oe_nxt = 1'b0;
        end
      end else if (tick_r) begin
        por_nxt = por_r + 16'h0001;
      end
      PWR_RUN: begin
        rst_oe_nxt = flt_rst;
        if (req_eff_r) begin
          st_nxt = PWR_STBY;
        end
      end
      PWR_STBY: begin
        rst_oe_nxt = flt_rst;
        if (!req_eff_r) begin
          st_nxt = PWR_RUN;
        end
      end
      default: st_nxt = PWR_OFF;
    endcase
    // Watchdog only counts once the processor is out of reset
    if ((sys_on && !wdog_ok) || (st_r != PWR_OFF && (long_ev || flt_off))) begin
      st_nxt = PWR_OFF;
      rst_oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_r <= PWR_OFF;
      por_r <= 16'h0000;
      flt_r <= 12'h000;
      rst_oe_r <= 1'b1;
      fseen_r <= 1'b0;
      flt_q_r <= 1'b0;
      regs_r <= 1'b0;
      stby_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      por_r <= por_nxt;
      flt_r <= flt_nxt;
      rst_oe_r <= rst_oe_nxt;
      fseen_r <= fseen_nxt;
      flt_q_r <= FAULT_IN;
      regs_r <= (st_nxt != PWR_OFF);
      stby_r <= (st_nxt == PWR_STBY);
    end
  end

  // ----------------------------------------
  // Interrupt status, masks, config, readback
  // ----------------------------------------
  logic [3:0] status_r, status_nxt, mask_r, mask_nxt, irq_set, irq_clr;
  logic irq_oe_r, irq_oe_nxt;

  always_comb begin
    irq_set = 4'h0;
    irq_set[`PCPI_IRQ_BTN_REL] = btn_rel_ev;
    irq_set[`PCPI_IRQ_BTN_PRS] = btn_prs_ev;
    irq_set[`PCPI_IRQ_FAULT] = FAULT_IN & ~flt_q_r;
    irq_set[`PCPI_IRQ_STBY] = req_eff_nxt ^ req_eff_r;
    irq_clr = 4'h0;
    if (rif.wr_en && rif.addr == `PCPI_REG_STATUS) begin
      irq_clr = rif.wdata[3:0];
    end
    // A new event in the clearing cycle survives; masks never stop it
    status_nxt = (status_r & ~irq_clr) | irq_set;
    if (st_r == PWR_OFF) begin
      status_nxt[`PCPI_IRQ_BTN_REL] = 1'b0;
      status_nxt[`PCPI_IRQ_BTN_PRS] = 1'b0;
    end
    mask_nxt = mask_r;
    if (rif.wr_en && rif.addr == `PCPI_REG_MASK) begin
      mask_nxt = rif.wdata[3:0];
    end
    cfg_nxt = cfg_r;
    if (rif.wr_en && rif.addr == `PCPI_REG_CONFIG) begin
      cfg_nxt = rif.wdata[4:0];
    end
    irq_oe_nxt = |(status_r & ~mask_r);
    case (rif.rd_addr)
      `PCPI_REG_STATUS: rif.rdata = {4'h0, status_r};
      `PCPI_REG_MASK: rif.rdata = {4'h0, mask_r};
      `PCPI_REG_SENSE: rif.rdata = {2'h0, irq_pin, rst_pin, wdog_ok, FAULT_IN,
                                    btn_db_r, req_q};
      `PCPI_REG_CONFIG: rif.rdata = {3'h0, cfg_r};
      default: rif.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      status_r <= `PCPI_STATUS_RST;
      mask_r <= `PCPI_MASK_RST;
      cfg_r <= `PCPI_CFG_RST;
      irq_oe_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      cfg_r <= cfg_nxt;
      irq_oe_r <= irq_oe_nxt;
    end
  end

  // Open-drain pins only ever pull low
  assign SDA_OUT = 1'b0;
  assign PROCESSOR_RESET_OUT_N_O = 1'b0;
  assign PROCESSOR_RESET_OUT_N_OE = rst_oe_r;
  assign IRQ_OUT_N_O = 1'b0;
  assign IRQ_OUT_N_OE = irq_oe_r;
  assign REGS_ON = regs_r;
  assign STANDBY_ACTIVE = stby_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  AST_REQ_XOR: assert property (tick_r |=> rq_sh_r[0] == $past(req_raw))
    else $error("request sense not pin xor polarity");
  AST_HOLDOFF: assert property ($rose(req_eff_r) |-> $past(hold_r >= hold_lim))
    else $error("request accepted before holdoff expired");
  AST_IRQ_LEVEL: assert property (1'b1 |=> IRQ_OUT_N_OE == $past(|(status_r & ~mask_r)))
    else $error("interrupt pin does not follow unmasked status");
  AST_W1C: assert property ((irq_clr[0] && !irq_set[0]) |=> !status_r[0])
    else $error("write one did not clear status");
  AST_SET_WINS: assert property ((irq_set[0] && st_r != PWR_OFF) |=> status_r[0])
    else $error("status event lost");
  AST_MASKED: assert property ((&mask_r) [*2] |-> !IRQ_OUT_N_OE)
    else $error("masked status pulled interrupt low");
  AST_MASK_RST: assert property ($past(SYS_RST) |-> mask_r == `PCPI_MASK_RST)
    else $error("masks not set after reset");
  AST_UNMASK: assert property (($fell(mask_r[0]) && status_r[0]) |=> IRQ_OUT_N_OE)
    else $error("unmasking pending status did not assert interrupt");
  AST_WDOG_OFF: assert property ((sys_on && !wdog_ok) |=> st_r == PWR_OFF)
    else $error("watchdog did not force off");
  AST_WDOG_MASK: assert property ((st_r == PWR_START && !long_ev && !flt_off)
    |=> st_r != PWR_OFF)
    else $error("watchdog acted during start-up");
  AST_STBY_RUN: assert property ($rose(st_r == PWR_STBY) |-> $past(st_r) == PWR_RUN)
    else $error("standby entered from other than run");
  AST_RST_REL: assert property ((!FAULT_RESET_MODE_ENABLE && $fell(rst_oe_r))
    |-> $past(st_r) == PWR_RDLY)
    else $error("reset released outside start-up end");
  AST_FLT_RST: assert property ((flt_rst && st_r == PWR_RUN) |=> PROCESSOR_RESET_OUT_N_OE)
    else $error("persisting fault did not assert reset");
  AST_OFF_CLR: assert property ((st_r == PWR_OFF) |=> !status_r[`PCPI_IRQ_BTN_REL])
    else $error("button status kept through off state");

  COV_STBY: cover property (st_r == PWR_RUN ##1 st_r == PWR_STBY);
  COV_LONG: cover property (long_ev);
  COV_WRITE: cover property (rif.wr_en);
  COV_IRQ: cover property ($rose(IRQ_OUT_N_OE));
endmodule
`default_nettype wire

// [pcpi_host.sv]
// Purpose: Host controller model driving the two-wire bus as open drain
// Assumes: Bit period of 8 CLK cycles (320 ns), pull-ups on both lines
// Notes: Lines are released between frames, so the pull-ups hold them high
`timescale 1ns/100ps
`default_nettype none
module pcpi_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  logic ld;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    ld = 1'b1;
  end
  task automatic q(input logic c, input logic d);
    @(posedge clk);
    scl_oe <= ~c;
    sda_oe <= ~d;
    @(posedge clk);
  endtask
  // Data moves only while the clock is low, two CLK cycles after the fall
  task automatic bit_io(input logic d, output logic s);
    q(1'b0, ld);
    q(1'b0, d);
    q(1'b1, d);
    s = sda;
    q(1'b1, d);
    ld = d;
  endtask
  task automatic start();
    q(1'b0, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
    q(1'b0, 1'b0);
    ld = 1'b0;
  endtask
  task automatic stop();
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
    ld = 1'b1;
  endtask
  task automatic send8(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv8(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule
`default_nettype wire

// [pcpi_top_bench.sv]
// Purpose: Self-checking bench of the control-pin block
// Assumes: SLOW_DIV of 4 so slow timers finish quickly
// Notes: Long press and fault timing are left to the design assertions
`timescale 1ns/100ps
`default_nettype none
`include "pcpi_defs.svh"
module pcpi_top_bench;
  localparam int DIV = 4;
  localparam int HOLD_CYC = int'(`PCPI_TK(`PCPI_T_HOLD_STEP_US)) * DIV;
  localparam int DB_MID_CYC = int'(`PCPI_TK(`PCPI_T_DBNC_MID_US)) * DIV;
  localparam int DB_SHORT_CYC = int'(`PCPI_TK(`PCPI_T_DBNC_SHORT_US)) * DIV;
  logic clk = 1'b0;
  logic btn = 1'b1;
  logic [1:0] h;
  logic sys_rst = 1'b1;
  logic lp_req = 1'b0;
  logic wdog = 1'b1;
  logic pwr_on = 1'b0;
  logic seq_done = 1'b0;
  logic h_scl_oe, h_sda_oe, d_sda_oe, rst_oe, irq_oe, regs_on, stby, a, pol;
  logic [7:0] d;
  logic [31:0] rnd = 32'h87C53723;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  wire scl;
  wire sda;
  assign scl = ~h_scl_oe;
  assign sda = ~(h_sda_oe | d_sda_oe);
  always #20 clk = ~clk;
  pcpi_host host (.clk(clk), .sda(sda), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));
  pcpi_top #(.SLOW_DIV(DIV)) DUT (
    .CLK(clk), .SYS_RST(sys_rst), .LP_REQUEST_IN(lp_req), .WATCHDOG_HARD_RESET_IN(wdog),
    .PUSH_BUTTON_IN(btn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(d_sda_oe),
    .PROCESSOR_RESET_OUT_N_I(~rst_oe), .PROCESSOR_RESET_OUT_N_O(),
    .PROCESSOR_RESET_OUT_N_OE(rst_oe), .IRQ_OUT_N_I(~irq_oe), .IRQ_OUT_N_O(),
    .IRQ_OUT_N_OE(irq_oe), .POWER_ON_CMD(pwr_on), .SEQ_DONE(seq_done), .FAULT_IN(1'b0),
    .FAULT_RESET_MODE_ENABLE(1'b0), .RESET_RELEASE_DELAY_SEL(3'h0),
    .LONG_PRESS_TIME_SEL(2'h3), .REGS_ON(regs_on), .STANDBY_ACTIVE(stby)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    host.start();
    host.send8({`PCPI_I2C_ADDR, 1'b0}, a);
    chk("addr_ack", 8'h01, {7'h00, a});
    host.send8(r, a);
    host.send8(v, a);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] v);
    host.start();
    host.send8({`PCPI_I2C_ADDR, 1'b0}, a);
    host.send8(r, a);
    host.start();
    host.send8({`PCPI_I2C_ADDR, 1'b1}, a);
    host.recv8(1'b1, v);
    host.stop();
  endtask
  // Hang guard: a full pass needs about 25500 cycles, mostly press debounce
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("rst_oe", 8'h01, {7'h00, rst_oe});
    rd(`PCPI_REG_MASK, d);
    chk("mask_rst", 8'h0F, d);
    host.start();
    host.send8(8'h00, a);
    host.stop();
    chk("gcall_ack", 8'h00, {7'h00, a});
    rnd = lfsr(rnd);
    pol = rnd[0];
    h = rnd[2:1];
    // Middle press debounce keeps the run short; long would need 98k cycles
    wr(`PCPI_REG_CONFIG, {3'h0, 2'h2, h, pol});
    @(posedge clk);
    lp_req <= pol;
    pwr_on <= 1'b1;
    @(posedge clk);
    pwr_on <= 1'b0;
    seq_done <= 1'b1;
    for (n = 0; n < 600 && rst_oe !== 1'b0; n++) @(posedge clk);
    chk("rel_dly", 8'h01, {7'h00, n >= 264 && n <= 280});
    chk("rst_rel", 8'h00, {7'h00, rst_oe});
    @(posedge clk);
    lp_req <= ~pol;
    for (n = 0; n < 600 && stby !== 1'b1; n++) @(posedge clk);
    chk("stby_in", 8'h01, {7'h00, stby && n >= 8 + HOLD_CYC * h});
    chk("stby_hold", 8'h01, {7'h00, n <= 40 + HOLD_CYC * h});
    rd(`PCPI_REG_STATUS, d);
    chk("stat_masked", 8'h08, {4'h0, d[3], irq_oe, 2'h0});
    wr(`PCPI_REG_MASK, 8'h07);
    repeat (2) @(posedge clk);
    chk("irq_unmask", 8'h01, {7'h00, irq_oe});
    wr(`PCPI_REG_STATUS, 8'h08);
    repeat (2) @(posedge clk);
    chk("irq_clear", 8'h00, {7'h00, irq_oe});
    rd(`PCPI_REG_SENSE, d);
    chk("sense", 8'h39, d);
    rnd = lfsr(rnd);
    wr(`PCPI_REG_MASK, rnd[7:0]);
    rd(`PCPI_REG_MASK, d);
    chk("mask_rw", {4'h0, rnd[3:0]}, d);
    // Only the press event may pull the pin low during the press
    wr(`PCPI_REG_MASK, 8'h0D);
    @(posedge clk);
    btn <= 1'b0;
    for (n = 0; n < 20000 && irq_oe !== 1'b1; n++) @(posedge clk);
    chk("prs_dbnc", 8'h01, {7'h00, n >= DB_MID_CYC && n <= DB_MID_CYC + 20});
    rd(`PCPI_REG_STATUS, d);
    chk("stat_prs", 8'h02, d);
    wr(`PCPI_REG_STATUS, 8'h02);
    @(posedge clk);
    btn <= 1'b1;
    repeat (DB_SHORT_CYC + 40) @(posedge clk);
    chk("rel_masked", 8'h00, {7'h00, irq_oe});
    rd(`PCPI_REG_STATUS, d);
    chk("stat_rel", 8'h01, d);
    wr(`PCPI_REG_MASK, 8'h0C);
    repeat (2) @(posedge clk);
    chk("rel_unmask", 8'h01, {7'h00, irq_oe});
    @(posedge clk);
    wdog <= 1'b0;
    repeat (20) @(posedge clk);
    chk("wdog_off", 8'h01, {6'h00, regs_on, rst_oe});
    rd(`PCPI_REG_STATUS, d);
    chk("off_clr", 8'h00, {d[7:0] | {7'h00, irq_oe}});
    // Turn on again with the watchdog still low: masked until reset release
    @(posedge clk);
    pwr_on <= 1'b1;
    @(posedge clk);
    pwr_on <= 1'b0;
    repeat (100) @(posedge clk);
    chk("wdog_mask", 8'h01, {7'h00, regs_on});
    repeat (300) @(posedge clk);
    chk("wdog_run", 8'h00, {7'h00, regs_on});
    results();
  end
endmodule
`default_nettype wire
